// ==== acl_ctrl.sv ====
`timescale 1ns/1ps
// Functional notes
// RQ1 - interrupt on each completion when enabled
// RQ2 - done flag sets on every completion
// RQ3 - wait mode keeps converting; software drops continuous
// RQ4 - single conversion falls to low power
// RQ5 - stop without async clock aborts conversion
// RQ6 - after stop, restart only on write
// RQ7 - async clock keeps converting through stop
// RQ8 - external mode in stop waits for trigger
// RQ9 - hardware trigger absent, tied inactive
// RQ10 - permitted break clears stay cleared
// RQ11 - blocked break leaves flags unchanged
// RQ12 - two-step clear spans break correctly
// RQ13 - analog inputs share port pads
// RQ14 - write or low read clears done
// RQ15 - write aborts and restarts unless off
// RQ16 - continuous converts until reset, stop, write
// RQ17 - break state and permit inputs gate clears
module acl_ctrl #(
  parameter int CONV_CYCLES = acl_pkg::ACL_CONV_CYCLES
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // status/control register access
  input wire logic SC_WR_I,
  input wire acl_pkg::acl_ctl_t SC_WDATA_I,
  output acl_pkg::acl_ctl_t SC_RDATA_O,
  // result register access
  input wire logic RES_HI_RD_I,
  input wire logic RES_LO_RD_I,
  input wire logic MODE_8BIT_I,
  output logic [acl_pkg::ACL_RES_W-1:0] RESULT_O,
  // configuration from the clock register
  input wire logic ASYNC_CLOCK_ENABLE_I,
  input wire logic EXTERNAL_CONVERT_MODE_I,
  // system state
  input wire logic WAIT_I,
  input wire logic STOP_I,
  input wire logic BREAK_I,
  input wire logic BREAK_CLEAR_PERMIT_I,
  // analog front end and pads
  input wire logic [acl_pkg::ACL_RES_W-1:0] SAMPLE_I,
  input wire logic [acl_pkg::ACL_PADS-1:0] GPIO_OE_I,
  output logic [acl_pkg::ACL_PADS-1:0] ANALOG_SEL_O,
  output logic [acl_pkg::ACL_PADS-1:0] PAD_OE_O,
  // status
  output logic CONV_DONE_FLAG_O,
  output logic IRQ_O,
  output logic BUSY_O,
  output logic LOW_POWER_O
);
  import acl_pkg::*;

  acl_ctl_t ctl_ff;
  logic done_flag_ff, nxt_done_flag;
  logic stopped_ff, nxt_stopped;
  logic pend_ff, nxt_pend;
  logic interlock_ff, nxt_interlock;
  logic [ACL_RES_W-1:0] result_ff;
  logic conv_busy;
  logic conv_done;
  logic [ACL_RES_W-1:0] conv_data;

  // no trigger pin on this variant; the path stays but never fires
  wire hw_trigger = ACL_HW_TRIGGER_PRESENT; // [RQ9]

  // flag clears are gated while a break is held and not permitted
  wire clear_ok = !BREAK_I || BREAK_CLEAR_PERMIT_I; // [RQ17] [RQ10] [RQ11]
  wire stop_abort = STOP_I && !ASYNC_CLOCK_ENABLE_I; // [RQ5]
  wire ext_hold = STOP_I && ASYNC_CLOCK_ENABLE_I && EXTERNAL_CONVERT_MODE_I; // [RQ8]
  wire trig_ok = !ext_hold || hw_trigger; // [RQ8]

  wire wr_go = SC_WR_I && !acl_chan_off(SC_WDATA_I.channel) && !stop_abort; // [RQ15]
  // continuous runs on through wait and through stop with the async clock
  wire cont_go = conv_done && ctl_ff.continuous && !acl_chan_off(ctl_ff.channel)
                 && !stopped_ff && !stop_abort && !SC_WR_I; // [RQ16] [RQ3] [RQ7]
  wire want_start = wr_go || cont_go || (pend_ff && !SC_WR_I && !stop_abort);
  wire start = want_start && trig_ok; // [RQ8]
  wire abort = SC_WR_I || stop_abort; // [RQ15] [RQ5]

  wire flag_clear = clear_ok && (SC_WR_I || RES_LO_RD_I); // [RQ14]
  wire hi_step = clear_ok && RES_HI_RD_I && !MODE_8BIT_I; // [RQ12]
  wire lo_step = clear_ok && RES_LO_RD_I; // [RQ12]
  wire transfer = conv_done && !(interlock_ff && !MODE_8BIT_I);

  // a completion in the clearing cycle wins, so no event is lost
  assign nxt_done_flag = conv_done ? 1'b1 : (flag_clear ? 1'b0 : done_flag_ff); // [RQ2] [RQ14]
  assign nxt_stopped = stop_abort ? 1'b1 : (SC_WR_I ? 1'b0 : stopped_ff); // [RQ6]
  assign nxt_pend = want_start && !trig_ok && !stop_abort; // [RQ8]
  assign nxt_interlock = hi_step ? 1'b1 : (lo_step ? 1'b0 : interlock_ff); // [RQ12]

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctl_ff <= ACL_CTL_RESET;
    end else if (SC_WR_I) begin
      ctl_ff <= SC_WDATA_I;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      done_flag_ff <= 1'b0;
      stopped_ff <= 1'b0;
      pend_ff <= 1'b0;
      interlock_ff <= 1'b0;
    end else begin
      done_flag_ff <= nxt_done_flag;
      stopped_ff <= nxt_stopped;
      pend_ff <= nxt_pend;
      interlock_ff <= nxt_interlock;
    end
  end

  // results survive stop; only a new completion replaces them
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      result_ff <= '0;
    end else if (transfer) begin
      result_ff <= conv_data; // [RQ6] [RQ16]
    end
  end

  acl_conv_seq #(
    .CONV_CYCLES(CONV_CYCLES)
  ) u_seq (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .start_i(start),
    .abort_i(abort),
    .sample_i(SAMPLE_I),
    .busy_o(conv_busy),
    .done_o(conv_done),
    .data_o(conv_data)
  );

  acl_pin_route u_pins (
    .channel_i(ctl_ff.channel),
    .enable_i(!acl_chan_off(ctl_ff.channel)),
    .gpio_oe_i(GPIO_OE_I),
    .analog_sel_o(ANALOG_SEL_O),
    .pad_oe_o(PAD_OE_O)
  );

  assign SC_RDATA_O = ctl_ff;
  assign RESULT_O = result_ff;
  assign CONV_DONE_FLAG_O = done_flag_ff;
  assign IRQ_O = done_flag_ff && ctl_ff.irq_en; // [RQ1]
  assign BUSY_O = conv_busy;
  // converter idles in low power whenever it is not converting; a held start waits there too
  assign LOW_POWER_O = !conv_busy; // [RQ4] [RQ8]

  chk_irq_on_done: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ1]
    conv_done && ctl_ff.irq_en && !SC_WR_I |=> IRQ_O) else $error("no interrupt after completion");

  chk_flag_sets: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ2]
    conv_done |=> CONV_DONE_FLAG_O) else $error("done flag missed a completion");

  chk_single_lowpower: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ4]
    conv_done && !ctl_ff.continuous && !SC_WR_I && !pend_ff |-> LOW_POWER_O ##1 LOW_POWER_O)
    else $error("single conversion did not drop to low power");

  chk_stop_aborts: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ5]
    STOP_I && !ASYNC_CLOCK_ENABLE_I |=> !BUSY_O && LOW_POWER_O) else $error("stop did not abort");

  chk_stop_no_resume: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ6]
    stopped_ff && !SC_WR_I && !BUSY_O |=> !BUSY_O) else $error("resumed without a write");

  chk_result_holds: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ6]
    !conv_done |=> RESULT_O == $past(RESULT_O)) else $error("result changed without completion");

  chk_async_runs: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ7]
    STOP_I && ASYNC_CLOCK_ENABLE_I && BUSY_O && !SC_WR_I && !conv_done |=> BUSY_O || conv_done)
    else $error("stop with async clock disturbed conversion");

  chk_ext_waits: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ8]
    ext_hold && !BUSY_O |=> !BUSY_O) else $error("converted in stop without trigger");

  chk_break_permit_clear: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ10]
    BREAK_I && BREAK_CLEAR_PERMIT_I && RES_LO_RD_I && !conv_done ##1 !conv_done |-> !CONV_DONE_FLAG_O)
    else $error("permitted break clear did not stick");

  chk_break_protect: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ11]
    BREAK_I && !BREAK_CLEAR_PERMIT_I && CONV_DONE_FLAG_O |=> CONV_DONE_FLAG_O)
    else $error("flag changed during protected break");

  chk_two_step: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ12]
    interlock_ff && BREAK_I && !BREAK_CLEAR_PERMIT_I |=> interlock_ff) else $error("first step lost in break");

  chk_clear_on_access: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ14]
    (SC_WR_I || RES_LO_RD_I) && clear_ok && !conv_done |=> !CONV_DONE_FLAG_O)
    else $error("done flag not cleared by access");

  chk_write_restarts: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ15]
    SC_WR_I && !acl_chan_off(SC_WDATA_I.channel) && !stop_abort && trig_ok |=> BUSY_O)
    else $error("write did not start a conversion");

  chk_write_off: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ15]
    SC_WR_I && acl_chan_off(SC_WDATA_I.channel) |=> !BUSY_O) else $error("all-ones write left converter on");

  chk_continuous: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    cont_go && trig_ok |=> BUSY_O) else $error("continuous mode did not restart");

  chk_wait_runs: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ3]
    WAIT_I && BUSY_O && !SC_WR_I && !stop_abort |=> BUSY_O || conv_done)
    else $error("wait mode disturbed a conversion");

  chk_ext_lowpower: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ8]
    ext_hold && pend_ff |-> LOW_POWER_O && !BUSY_O) else $error("held start left converter powered");

  chk_interlock_holds: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ12]
    interlock_ff && !MODE_8BIT_I && conv_done |=> RESULT_O == $past(RESULT_O))
    else $error("result replaced while read interlock held");

  chk_result_update: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ16]
    conv_done && !interlock_ff |=> RESULT_O == $past(conv_data)) else $error("completion did not update result");

  chk_offchan_isolated: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ13]
    acl_chan_off(ctl_ff.channel) |-> ANALOG_SEL_O == '0) else $error("pad routed while converter off");

  chk_pad_released: assert property (@(posedge CLK_I) disable iff (RST_I) // [RQ13]
    (ANALOG_SEL_O & PAD_OE_O) == '0) else $error("analog pad still driven by port");

endmodule

// ==== acl_pkg.sv ====
package acl_pkg;

  localparam int ACL_CLK_PERIOD_NS = 100;
  localparam int ACL_CONV_TIME_NS = 2400;
  localparam int ACL_CONV_CYCLES = (ACL_CONV_TIME_NS + ACL_CLK_PERIOD_NS - 1) / ACL_CLK_PERIOD_NS;
  localparam int ACL_RES_W = 10;
  localparam int ACL_PADS = 10;
  localparam int ACL_CH_W = 5;

  localparam logic [ACL_CH_W-1:0] ACL_CH_OFF = 5'h1F;
  localparam logic [ACL_CH_W-1:0] ACL_CH_PAD8 = 5'h18;
  localparam logic [ACL_CH_W-1:0] ACL_CH_PAD9 = 5'h19;
  localparam logic [ACL_CH_W-1:0] ACL_CH_LAST_LOW = 5'h07;

  typedef struct packed {
    logic irq_en;
    logic continuous;
    logic [ACL_CH_W-1:0] channel;
  } acl_ctl_t;

  localparam acl_ctl_t ACL_CTL_RESET = '{irq_en: 1'b0, continuous: 1'b0, channel: ACL_CH_OFF};

  localparam logic ACL_HW_TRIGGER_PRESENT = 1'b0;

  function automatic logic acl_chan_off(input logic [ACL_CH_W-1:0] ch);
    return ch == ACL_CH_OFF;
  endfunction

endpackage

// ==== acl_conv_seq.sv ====
`timescale 1ns/1ps
module acl_conv_seq #(
  parameter int CONV_CYCLES = acl_pkg::ACL_CONV_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic abort_i,
  // sample from analog front end
  input wire logic [acl_pkg::ACL_RES_W-1:0] sample_i,
  // status
  output logic busy_o,
  output logic done_o,
  output logic [acl_pkg::ACL_RES_W-1:0] data_o
);
  import acl_pkg::*;

  initial begin
    if (CONV_CYCLES < 2 || CONV_CYCLES > 4096) $error("CONV_CYCLES out of range");
  end

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} acl_seq_t;

  acl_seq_t state_ff, nxt_state;
  logic [12:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;
  logic [ACL_RES_W-1:0] data_ff, nxt_data;

  wire last_cycle = (state_ff == SEQ_RUN) && (cnt_ff == 13'(CONV_CYCLES - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_data = data_ff;
    case (state_ff)
      SEQ_IDLE: begin
        nxt_cnt = '0;
      end
      SEQ_RUN: begin
        nxt_cnt = cnt_ff + 13'h0001;
        if (last_cycle) begin
          // counter parks at zero so it never shows the overrun value
          nxt_cnt = '0;
          nxt_state = SEQ_IDLE;
          nxt_done = 1'b1;
          nxt_data = sample_i;
        end
      end
      default: nxt_state = SEQ_IDLE;
    endcase
    // a fresh start overrides both abort and completion
    if (abort_i && !start_i) begin
      nxt_state = SEQ_IDLE;
      nxt_done = 1'b0;
    end
    if (start_i) begin
      nxt_state = SEQ_RUN;
      nxt_cnt = '0;
      nxt_done = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= SEQ_IDLE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
      data_ff <= nxt_data;
    end
  end

  assign busy_o = (state_ff == SEQ_RUN);
  assign done_o = done_ff;
  assign data_o = data_ff;

  chk_seq_count_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_ff < 13'(CONV_CYCLES)) else $error("sequencer count overran");
  chk_seq_done_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    done_o |-> !$past(abort_i) && !busy_o || $past(start_i)) else $error("done while running");

endmodule

// ==== acl_pin_route.sv ====
`timescale 1ns/1ps
module acl_pin_route (
  input wire logic [acl_pkg::ACL_CH_W-1:0] channel_i,
  input wire logic enable_i,
  input wire logic [acl_pkg::ACL_PADS-1:0] gpio_oe_i,
  output logic [acl_pkg::ACL_PADS-1:0] analog_sel_o,
  output logic [acl_pkg::ACL_PADS-1:0] pad_oe_o
);
  import acl_pkg::*;

  // pads 0..7 map directly; pads 8 and 9 sit high in the channel space
  wire low_pad = channel_i <= ACL_CH_LAST_LOW;
  wire [ACL_PADS-1:0] low_sel = ACL_PADS'(10'h001 << channel_i[2:0]);
  wire [ACL_PADS-1:0] hi_sel = {channel_i == ACL_CH_PAD9, channel_i == ACL_CH_PAD8, 8'h00};
  wire [ACL_PADS-1:0] pad_sel = low_pad ? low_sel : hi_sel;

  assign analog_sel_o = enable_i ? pad_sel : '0; // [RQ13]
  // the selected pad is released from its port driver so the input is not loaded
  assign pad_oe_o = gpio_oe_i & ~analog_sel_o; // [RQ13]

endmodule

// ==== acl_core_model.sv ====
`timescale 1ns/1ps
module acl_core_model
  import acl_pkg::*;
(
  // bus clock
  input wire logic clk_i,
  // register strobes toward the converter
  output logic sc_wr_o,
  output acl_ctl_t sc_wdata_o,
  output logic res_hi_rd_o,
  output logic res_lo_rd_o
);
  initial begin
    sc_wr_o = 1'b0;
    sc_wdata_o = ACL_CTL_RESET;
    res_hi_rd_o = 1'b0;
    res_lo_rd_o = 1'b0;
  end

  // data inverted after the strobe so a stale value never reads as valid
  task automatic write_sc(input acl_ctl_t d);
    @(negedge clk_i);
    sc_wr_o = 1'b1;
    sc_wdata_o = d;
    @(negedge clk_i);
    sc_wr_o = 1'b0;
    sc_wdata_o = ~d;
  endtask

  // hi=1 is the first step of the two-step clear
  task automatic read_res(input logic hi);
    @(negedge clk_i);
    res_hi_rd_o = hi;
    res_lo_rd_o = !hi;
    @(negedge clk_i);
    res_hi_rd_o = 1'b0;
    res_lo_rd_o = 1'b0;
  endtask
endmodule

// ==== acl_ctrl_tb.sv ====
`timescale 1ns/1ps
module acl_ctrl_tb;
  import acl_pkg::*;
  localparam int CC = 4;
  logic clk, rst, wr, hi_rd, lo_rd, async_en, ext_mode, wait_md, stop, brk, permit;
  acl_ctl_t wdata, rdata;
  logic [ACL_RES_W-1:0] sample, result;
  logic [ACL_PADS-1:0] gpio_oe, sel, pad_oe;
  logic flag, irq, busy, low_pw, mode8;
  int miscompares = 0;
  int n_compared = 0;

  acl_ctrl #(.CONV_CYCLES(CC)) i_acl_ctrl (.CLK_I(clk), .RST_I(rst), .SC_WR_I(wr), .SC_WDATA_I(wdata),
    .SC_RDATA_O(rdata), .RES_HI_RD_I(hi_rd), .RES_LO_RD_I(lo_rd), .MODE_8BIT_I(mode8), .RESULT_O(result),
    .ASYNC_CLOCK_ENABLE_I(async_en), .EXTERNAL_CONVERT_MODE_I(ext_mode), .WAIT_I(wait_md), .STOP_I(stop),
    .BREAK_I(brk), .BREAK_CLEAR_PERMIT_I(permit), .SAMPLE_I(sample), .GPIO_OE_I(gpio_oe),
    .ANALOG_SEL_O(sel), .PAD_OE_O(pad_oe), .CONV_DONE_FLAG_O(flag), .IRQ_O(irq), .BUSY_O(busy),
    .LOW_POWER_O(low_pw));

  acl_core_model i_acl_core_model (.clk_i(clk), .sc_wr_o(wr), .sc_wdata_o(wdata), .res_hi_rd_o(hi_rd),
    .res_lo_rd_o(lo_rd));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr_sc(input logic ie, input logic co, input logic [ACL_CH_W-1:0] ch);
    i_acl_core_model.write_sc({ie, co, ch});
    cyc(1);
  endtask

  task automatic rd(input logic hi);
    i_acl_core_model.read_res(hi);
    cyc(1);
  endtask

  // bounded wait; a missing completion counts as a mismatch
  task automatic wait_done;
    int i;
    i = 0;
    while (flag !== 1'b1 && i < 30) begin
      @(negedge clk);
      i++;
    end
    chk(flag, 1'b1);
  endtask

  initial begin
    rst = 1'b1;
    async_en = 1'b0;
    ext_mode = 1'b0;
    wait_md = 1'b0;
    stop = 1'b0;
    brk = 1'b0;
    permit = 1'b0;
    sample = 10'h2A5;
    gpio_oe = 10'h3FF;
    mode8 = 1'b0;
    cyc(6);
    rst = 1'b0;
    chk(flag, 1'b0);
    chk(irq, 1'b0);
    chk(busy, 1'b0);
    chk(low_pw, 1'b1);
    chk(result, 10'h000);
    chk(rdata, ACL_CTL_RESET);
    chk(sel, 10'h000);
    chk(pad_oe, gpio_oe);
    wr_sc(1'b1, 1'b0, 5'h03);
    chk(sel, 10'h008);
    chk(pad_oe, 10'h3F7);
    wait_done;
    chk(irq, 1'b1);
    chk(result, 10'h2A5);
    cyc(2);
    chk(low_pw, 1'b1);
    rd(1'b0);
    chk(flag, 1'b0);
    chk(irq, 1'b0);
    sample = 10'h15A;
    wr_sc(1'b0, 1'b0, ACL_CH_PAD8);
    chk(sel, 10'h100);
    wait_done;
    chk(irq, 1'b0);
    wr_sc(1'b0, 1'b0, ACL_CH_OFF);
    chk(flag, 1'b0);
    chk(busy, 1'b0);
    chk(sel, 10'h000);
    // continuous through wait, then stop without async clock
    wait_md = 1'b1;
    wr_sc(1'b1, 1'b1, 5'h01);
    wait_done;
    chk(result, 10'h15A);
    sample = 10'h0C3;
    rd(1'b0);
    wait_done;
    chk(result, 10'h0C3);
    sample = 10'h3C0;
    cyc(2);
    stop = 1'b1;
    cyc(1);
    chk(busy, 1'b0);
    cyc(8);
    stop = 1'b0;
    wait_md = 1'b0;
    cyc(8);
    chk(busy, 1'b0);
    chk(result, 10'h0C3);
    wr_sc(1'b1, 1'b0, 5'h02);
    chk(flag, 1'b0);
    wait_done;
    chk(result, 10'h3C0);
    // stop with async clock, then external-convert mode
    async_en = 1'b1;
    stop = 1'b1;
    sample = 10'h111;
    wr_sc(1'b1, 1'b0, 5'h04);
    wait_done;
    chk(irq, 1'b1);
    chk(result, 10'h111);
    ext_mode = 1'b1;
    wr_sc(1'b1, 1'b0, 5'h05);
    cyc(8);
    chk(busy, 1'b0);
    chk(flag, 1'b0);
    chk(low_pw, 1'b1);
    stop = 1'b0;
    wait_done;
    ext_mode = 1'b0;
    async_en = 1'b0;
    // debug break gating
    brk = 1'b1;
    rd(1'b0);
    chk(flag, 1'b1);
    permit = 1'b1;
    rd(1'b0);
    chk(flag, 1'b0);
    brk = 1'b0;
    permit = 1'b0;
    cyc(2);
    chk(flag, 1'b0);
    wr_sc(1'b0, 1'b0, 5'h06);
    wait_done;
    rd(1'b1);
    brk = 1'b1;
    rd(1'b0);
    chk(flag, 1'b1);
    // conversion inside the break must not pass the armed interlock
    sample = 10'h2F0;
    wr_sc(1'b0, 1'b0, 5'h06);
    cyc(8);
    chk(flag, 1'b1);
    chk(result, 10'h111);
    brk = 1'b0;
    rd(1'b0);
    chk(flag, 1'b0);
    wr_sc(1'b0, 1'b0, 5'h06);
    wait_done;
    chk(result, 10'h2F0);
    // 8-bit mode: a high read arms nothing
    mode8 = 1'b1;
    rd(1'b1);
    sample = 10'h0AA;
    wr_sc(1'b0, 1'b0, 5'h07);
    chk(sel, 10'h080);
    wait_done;
    chk(result, 10'h0AA);
    end_of_test;
  end

  // tests need under two hundred cycles; 2000 is ample
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
endmodule
